//--- pkg/ivw_params.svh
`ifndef IVW_PARAMS_SVH
`define IVW_PARAMS_SVH

// ****************************************************************
// line count and vector layout
// ****************************************************************
`define IVW_NLINES      20
`define IVW_VEC_W       24
`define IVW_VEC_RESET   24'h008000
`define IVW_VEC_TRAP    24'h008004
`define IVW_VEC_LINE0   24'h008008

// ****************************************************************
// wake qualification and reserved lines, one bit per line; port A line number
// ****************************************************************
`define IVW_HALT_WAKE   20'h804F8
`define IVW_AHALT_WAKE  20'h804FA
`define IVW_RSVD_LINES  20'h18200
`define IVW_LINE_PORT_A 5'h03

// ****************************************************************
// register offsets (byte addresses)
// ****************************************************************
`define IVW_ADDR_W      12
`define IVW_OFS_STATUS  12'h000
`define IVW_OFS_MASK    12'h004
`define IVW_OFS_CTRL    12'h008
`define IVW_OFS_VECTOR  12'h00C
`define IVW_OFS_PIN     12'h010

// ****************************************************************
// field positions and encodings
// ****************************************************************
`define IVW_CTRL_MODE_LSB 0
`define IVW_CTRL_MODE_MSB 1
`define IVW_CTRL_P1_OUT   4
`define IVW_CTRL_P1_DIR   5
`define IVW_CTRL_P1_IRQ   6
`define IVW_PIN_LEVEL     0
`define IVW_PIN_TRAP      1
`define IVW_MODE_RUN      2'h0
`define IVW_MODE_HALT     2'h1
`define IVW_MODE_AHALT    2'h2

// ****************************************************************
// reset values
// ****************************************************************
`define IVW_STATUS_RST  20'h00000
`define IVW_MASK_RST    20'h00000
`define IVW_PCTRL_RST   3'h0

`endif

//--- pkg/ivw_pkg.sv
`include "ivw_params.svh"

// ****************************************************************
// shared types
// ****************************************************************
package ivw_pkg;

  // power mode of the core
  typedef enum logic [1:0] {
    IVW_RUN,
    IVW_HALT,
    IVW_AHALT
  } ivw_mode_e;

  // apb request from the master
  typedef struct packed {
    logic                   psel;
    logic                   penable;
    logic                   pwrite;
    logic [`IVW_ADDR_W-1:0] paddr;
    logic [31:0]            pwdata;
  } ivw_apb_req_s;

  // apb answer to the master
  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } ivw_apb_rsp_s;

endpackage : ivw_pkg

//--- src/ivw_top.sv
// The address map and register access over APB were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "ivw_params.svh"

module ivw_top (
  input  wire logic                  clk_sys_i,
  input  wire logic                  reset_n_i,
  input  wire ivw_pkg::ivw_apb_req_s apb_i,
  output var  ivw_pkg::ivw_apb_rsp_s apb_o,
  input  wire logic [19:0]           irq_lines_i,
  input  wire logic                  trap_i,
  input  wire logic                  core_fetch_i,
  output var  logic                  vec_valid_o,
  output var  logic [23:0]           vec_addr_o,
  output var  logic                  irq_o,
  output var  logic                  wake_o,
  output var  logic                  halted_o,
  input  wire logic                  port_a_pin1_i,
  output var  logic                  port_a_pin1_o,
  output var  logic                  port_a_pin1_oe_o,
  output var  logic                  port_a_pin1_pu_o
);
  import ivw_pkg::*;

  // ****************************************************************
  // helper functions
  // ****************************************************************

  // lowest pending line wins; returns {found, line}
  function automatic logic [5:0] ivw_pick(input logic [19:0] p);
    logic [5:0] r;
    r = 6'h00;
    for (int i = 19; i >= 0; i--) begin
      if (p[i]) begin
        r = {1'b1, 5'(i)};
      end
    end
    return r;
  endfunction : ivw_pick

  // vector slot of a numbered line, 4 bytes apart
  function automatic logic [23:0] ivw_line_vec(input logic [4:0] l);
    return `IVW_VEC_LINE0 + {17'h00000, l, 2'h0};
  endfunction : ivw_line_vec

  // register field to mode
  function automatic ivw_mode_e ivw_dec_mode(input logic [1:0] b);
    ivw_mode_e m;
    case (b)
      `IVW_MODE_HALT:  m = IVW_HALT;
      `IVW_MODE_AHALT: m = IVW_AHALT;
      default:         m = IVW_RUN;
    endcase
    return m;
  endfunction : ivw_dec_mode

  // mode to register field
  function automatic logic [1:0] ivw_enc_mode(input ivw_mode_e m);
    logic [1:0] b;
    case (m)
      IVW_HALT:  b = `IVW_MODE_HALT;
      IVW_AHALT: b = `IVW_MODE_AHALT;
      default:   b = `IVW_MODE_RUN;
    endcase
    return b;
  endfunction : ivw_enc_mode

  // ****************************************************************
  // state
  // ****************************************************************
  logic [19:0] status_q;         // sticky pending lines
  logic [19:0] status_d;         // next pending lines
  logic [19:0] mask_q;           // line enables
  ivw_mode_e   mode_q;           // current power mode
  ivw_mode_e   mode_d;           // next power mode
  logic [2:0]  pctrl_q;          // pin1 irq en, dir, out
  logic        trap_pend_q;      // trap waiting for fetch
  logic        p1_s1_q;          // pin sync stage 1
  logic        p1_s2_q;          // pin sync stage 2
  logic        p1_s3_q;          // delayed for edge detect
  logic        pready_q;         // apb answer strobe
  logic        pslverr_q;        // apb error answer
  logic [31:0] prdata_q;         // apb read data
  logic        vec_valid_q;      // vector answer strobe
  logic [23:0] vec_addr_q;       // last vector handed out
  logic        irq_q;            // interrupt level
  logic        wake_q;           // wake pulse
  logic        p1_oe_q;          // pin1 output enable
  logic        p1_out_q;         // pin1 output level
  logic        p1_pu_q;          // pin1 pull-up enable
  // reset image of the status flags, indexed per line
  localparam logic [19:0] ST_RST = `IVW_STATUS_RST;

  // ****************************************************************
  // apb decode
  // ****************************************************************
  wire         bus_acc  = apb_i.psel & apb_i.penable;
  wire         bus_fire = bus_acc & pready_q;     // transfer completes
  wire         wr_fire  = bus_fire & apb_i.pwrite;
  wire         sel_st   = apb_i.paddr == `IVW_OFS_STATUS;
  wire         sel_mk   = apb_i.paddr == `IVW_OFS_MASK;
  wire         sel_ct   = apb_i.paddr == `IVW_OFS_CTRL;
  wire         sel_vc   = apb_i.paddr == `IVW_OFS_VECTOR;
  wire         sel_pn   = apb_i.paddr == `IVW_OFS_PIN;
  wire         addr_hit = sel_st | sel_mk | sel_ct | sel_vc | sel_pn;
  wire         wr_st    = wr_fire & sel_st;
  wire         wr_mk    = wr_fire & sel_mk;
  wire         wr_ct    = wr_fire & sel_ct;
  wire [19:0]  w1c      = wr_st ? apb_i.pwdata[19:0] : 20'h00000;
  wire [1:0]   wr_mode  =
    apb_i.pwdata[`IVW_CTRL_MODE_MSB:`IVW_CTRL_MODE_LSB];

  // read view of the control register
  wire [31:0]  ctrl_rd  = {25'h0000000, pctrl_q, 2'h0,
                           ivw_enc_mode(mode_q)};
  wire [31:0]  pin_rd   = {30'h00000000, trap_pend_q, p1_s2_q};

  // read multiplexer; unmapped offsets read zero
  wire [31:0]  rd_mux   =
    sel_st ? {12'h000, status_q} :
    sel_mk ? {12'h000, mask_q} :
    sel_ct ? ctrl_rd :
    sel_vc ? {8'h00, vec_addr_q} :
    sel_pn ? pin_rd : 32'h00000000;

  // ****************************************************************
  // event sources
  // ****************************************************************
  wire         halted   = mode_q != IVW_RUN;
  // pin1 falls: joins the port A line only while running,
  // the pad is not usable as a wake source
  wire         p1_fall  = p1_s3_q & ~p1_s2_q;
  wire         p1_event = p1_fall & pctrl_q[2] & ~halted;
  wire [19:0]  p1_vec   = {16'h0000, p1_event, 3'h0};
  // reserved lines are cut off at the input
  wire [19:0]  events   = (irq_lines_i | p1_vec) &
                          ~`IVW_RSVD_LINES;
  wire [19:0]  pend     = status_q & mask_q;

  // ****************************************************************
  // wake qualification
  // ****************************************************************
  // only the listed lines may end each mode; the trap is
  // not a line and so never wakes
  wire [19:0]  wake_tbl = (mode_q == IVW_HALT) ? `IVW_HALT_WAKE :
                          (mode_q == IVW_AHALT) ? `IVW_AHALT_WAKE :
                          20'h00000;
  wire         wake_now = |(pend & wake_tbl);

  // wake beats a software mode write in the same cycle
  always_comb begin
    mode_d = mode_q;
    if (wake_now) begin
      mode_d = IVW_RUN;
    end else if (wr_ct) begin
      mode_d = ivw_dec_mode(wr_mode);
    end
  end

  // ****************************************************************
  // vector selection
  // ****************************************************************
  wire [5:0]   pick     = ivw_pick(pend);
  // trap first, then lowest line, else the reset vector
  wire [23:0]  vec_sel  = trap_pend_q ? `IVW_VEC_TRAP :
                          pick[5] ? ivw_line_vec(pick[4:0]) :
                          `IVW_VEC_RESET;

  // ****************************************************************
  // status flags, one flop per line
  // ****************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < `IVW_NLINES; gi++) begin : g_st
      // a new event wins over a clear in the same cycle
      assign status_d[gi] = events[gi] |
                            (status_q[gi] & ~w1c[gi]);
      always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
          status_q[gi] <= ST_RST[gi];
        end else begin
          status_q[gi] <= status_d[gi];
        end
      end
    end
  endgenerate

  // ****************************************************************
  // software registers
  // ****************************************************************
  // mask, pin control and mode
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      mask_q  <= `IVW_MASK_RST;
      pctrl_q <= `IVW_PCTRL_RST;
      mode_q  <= IVW_RUN;
    end else begin
      if (wr_mk) begin
        mask_q <= apb_i.pwdata[19:0] & ~`IVW_RSVD_LINES;
      end
      if (wr_ct) begin
        pctrl_q <= apb_i.pwdata[`IVW_CTRL_P1_IRQ:`IVW_CTRL_P1_OUT];
      end
      mode_q <= mode_d;
    end
  end

  // trap request held until the core fetches it
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      trap_pend_q <= 1'b0;
    end else begin
      trap_pend_q <= trap_i | (trap_pend_q & ~core_fetch_i);
    end
  end

  // ****************************************************************
  // apb answer
  // ****************************************************************
  // one wait state so that every answer leaves a flop
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h00000000;
    end else begin
      pready_q  <= bus_acc & ~pready_q;
      pslverr_q <= bus_acc & ~pready_q & ~addr_hit;
      if (bus_acc & ~pready_q & ~apb_i.pwrite) begin
        prdata_q <= rd_mux;
      end
    end
  end

  // ****************************************************************
  // core side
  // ****************************************************************
  // vector handed out one cycle after the fetch request
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      vec_valid_q <= 1'b0;
      vec_addr_q  <= `IVW_VEC_RESET;
    end else begin
      vec_valid_q <= core_fetch_i;
      if (core_fetch_i) begin
        vec_addr_q <= vec_sel;
      end
    end
  end

  // interrupt level and wake pulse
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      irq_q  <= 1'b0;
      wake_q <= 1'b0;
    end else begin
      irq_q  <= |(status_d & mask_q);
      wake_q <= wake_now;
    end
  end

  // ****************************************************************
  // port A pin1
  // ****************************************************************
  // two-flop synchroniser plus one stage for edge detect
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      p1_s1_q <= 1'b1;
      p1_s2_q <= 1'b1;
      p1_s3_q <= 1'b1;
    end else begin
      p1_s1_q <= port_a_pin1_i;
      p1_s2_q <= p1_s1_q;
      p1_s3_q <= p1_s2_q;
    end
  end

  // pad drive follows the next mode so it tracks mode_q
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      p1_oe_q  <= 1'b0;
      p1_out_q <= 1'b0;
      p1_pu_q  <= 1'b0;
    end else begin
      p1_oe_q  <= (mode_d == IVW_RUN) & pctrl_q[1];
      p1_out_q <= pctrl_q[0];
      p1_pu_q  <= mode_d != IVW_RUN;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign apb_o.pready     = pready_q;
  assign apb_o.pslverr    = pslverr_q;
  assign apb_o.prdata     = prdata_q;
  assign vec_valid_o      = vec_valid_q;
  assign vec_addr_o       = vec_addr_q;
  assign irq_o            = irq_q;
  assign wake_o           = wake_q;
  assign halted_o         = halted;
  assign port_a_pin1_o    = p1_out_q;
  assign port_a_pin1_oe_o = p1_oe_q;
  assign port_a_pin1_pu_o = p1_pu_q;

  // ****************************************************************
  // assertions
  // ****************************************************************
  AST_VEC_TRAP: assert property (@(posedge clk_sys_i)
    disable iff (!reset_n_i)
    core_fetch_i && trap_pend_q |=>
      vec_valid_o && vec_addr_o == `IVW_VEC_TRAP)
    else $error("trap vector wrong");

  AST_VEC_LINE: assert property (@(posedge clk_sys_i)
    disable iff (!reset_n_i)
    core_fetch_i && !trap_pend_q && pick[5] |=>
      vec_addr_o == `IVW_VEC_LINE0 +
        {17'h00000, $past(pick[4:0]), 2'h0})
    else $error("line vector wrong");

  AST_AWU_HALT: assert property (@(posedge clk_sys_i)
    disable iff (!reset_n_i)
    mode_q == IVW_HALT && pend == 20'h00002 && !wr_ct |=>
      mode_q == IVW_HALT ##0 !wake_o)
    else $error("auto wakeup ended halt");

  AST_AWU_AHALT: assert property (@(posedge clk_sys_i)
    disable iff (!reset_n_i)
    mode_q == IVW_AHALT && pend[1] |=>
      mode_q == IVW_RUN && wake_o)
    else $error("auto wakeup missed");

  AST_PORT_A: assert property (@(posedge clk_sys_i)
    disable iff (!reset_n_i)
    halted && pend[3] |=> mode_q == IVW_RUN)
    else $error("port A did not wake");

  AST_PORT_BE: assert property (@(posedge clk_sys_i)
    disable iff (!reset_n_i)
    mode_q == IVW_HALT && |pend[7:4] |=> wake_o)
    else $error("ports B-E did not wake");

  AST_PORT_F: assert property (@(posedge clk_sys_i)
    disable iff (!reset_n_i)
    halted && pend == 20'h00100 |=> !wake_o)
    else $error("port F woke");

  AST_SER_WAKE: assert property (@(posedge clk_sys_i)
    disable iff (!reset_n_i)
    mode_q == IVW_HALT && (pend[10] || pend[19]) |=> wake_o)
    else $error("serial did not wake");

  AST_TIMER: assert property (@(posedge clk_sys_i)
    disable iff (!reset_n_i)
    halted && (pend & ~20'h01800) == 20'h00000 |=> !wake_o)
    else $error("timer woke");

  AST_ASYNC: assert property (@(posedge clk_sys_i)
    disable iff (!reset_n_i)
    halted && (pend & ~20'h60000) == 20'h00000 |=> !wake_o)
    else $error("async serial woke");

  AST_NO_WAKE: assert property (@(posedge clk_sys_i)
    disable iff (!reset_n_i)
    halted && (pend & ~20'h06004) == 20'h00000 &&
      !wr_ct |=> halted && !wake_o)
    else $error("clock or timer woke");

  AST_PIN1: assert property (@(posedge clk_sys_i)
    disable iff (!reset_n_i)
    halted |-> !port_a_pin1_oe_o && port_a_pin1_pu_o)
    else $error("pin1 driven while halted");

  AST_RSVD: assert property (@(posedge clk_sys_i)
    disable iff (!reset_n_i)
    1'b1 |-> (status_q & `IVW_RSVD_LINES) == 20'h00000)
    else $error("reserved line pending");

endmodule : ivw_top
`default_nettype wire

//--- tb/ivw_core_model.sv
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// core model: asks for one vector per start, promptly or late
// ****************************************************************
module ivw_core_model (
  input  wire logic        clk_sys_i,
  input  wire logic        reset_n_i,
  input  wire logic        start_i,      // ask for one fetch
  input  wire logic [1:0]  delay_i,      // idle cycles before the fetch
  input  wire logic        vec_valid_i,  // answer strobe
  input  wire logic [23:0] vec_addr_i,   // answered vector
  output var  logic        core_fetch_o, // one-cycle fetch pulse
  output var  logic        done_o,       // fetch answered
  output var  logic        bad_o,        // sticky: late or unasked answer
  output var  logic [23:0] got_addr_o    // vector taken with the answer
);
  logic [1:0] cnt_q;  // remaining idle cycles
  logic       pend_q; // fetch still to be issued
  logic       wait_q; // answer due at this edge

  // sequencer; an answer off its slot is flagged, never absorbed
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cnt_q        <= 2'h0;
      pend_q       <= 1'b0;
      wait_q       <= 1'b0;
      core_fetch_o <= 1'b0;
      done_o       <= 1'b0;
      bad_o        <= 1'b0;
      got_addr_o   <= 24'h000000;
    end else begin
      core_fetch_o <= 1'b0;
      done_o       <= 1'b0;
      wait_q       <= core_fetch_o;
      if (start_i) begin
        cnt_q  <= delay_i;
        pend_q <= 1'b1;
      end else if (pend_q && cnt_q == 2'h0) begin
        core_fetch_o <= 1'b1;
        pend_q       <= 1'b0;
      end else if (pend_q) begin
        cnt_q <= cnt_q - 2'h1;
      end
      if (wait_q) begin
        done_o     <= 1'b1;
        got_addr_o <= vec_addr_i;
        bad_o      <= bad_o | ~vec_valid_i;
      end else if (vec_valid_i) begin
        bad_o <= 1'b1;
      end
    end
  end
endmodule : ivw_core_model

`default_nettype wire

//--- tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "ivw_params.svh"

// ****************************************************************
// bench top: apb master, event lines, pad and core model
// ****************************************************************
module tb;
  import ivw_pkg::*;
  logic         clk_sys_i = 1'b0;
  logic         reset_n_i = 1'b0;
  ivw_apb_req_s apb_req   = '0;
  ivw_apb_rsp_s apb_rsp;
  logic [19:0]  irq_lines = 20'h00000;
  logic         trap      = 1'b0;
  logic         start     = 1'b0;
  logic [1:0]   delay     = 2'h0;
  logic         pad_ext   = 1'b1; // external driver of the pad
  logic         core_fetch, vec_valid, irq, wake, halted;
  logic         pin_o, pin_oe, pin_pu, done, bad;
  logic [23:0]  vec_addr, got;
  wire          pad;
  int           errors      = 0;
  int           checks_done = 0;
  localparam logic [19:0] HALT_SET  = 20'h804F8; // 3-7, 10, 19
  localparam logic [19:0] AHALT_SET = 20'h804FA; // plus line 1
  localparam logic [19:0] RSVD      = 20'h18200; // 9, 15, 16

  // pad level: the block wins while it drives
  assign pad = pin_oe ? pin_o : pad_ext;
  always #2.5 clk_sys_i = ~clk_sys_i;

  ivw_top DUT (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
    .apb_i(apb_req), .apb_o(apb_rsp), .irq_lines_i(irq_lines),
    .trap_i(trap), .core_fetch_i(core_fetch), .vec_valid_o(vec_valid),
    .vec_addr_o(vec_addr), .irq_o(irq), .wake_o(wake),
    .halted_o(halted), .port_a_pin1_i(pad), .port_a_pin1_o(pin_o),
    .port_a_pin1_oe_o(pin_oe), .port_a_pin1_pu_o(pin_pu));
  ivw_core_model u_core (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
    .start_i(start), .delay_i(delay), .vec_valid_i(vec_valid),
    .vec_addr_i(vec_addr), .core_fetch_o(core_fetch), .done_o(done),
    .bad_o(bad), .got_addr_o(got));

  // ****************************************************************
  // reporting and compares
  // ****************************************************************
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : final_report

  task automatic chk_val(logic [31:0] g, logic [31:0] e, string m);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("wrong value at %0t: %s got %h exp %h", $time, m, g, e);
    end
  endtask : chk_val

  task automatic chk_bit(logic g, logic e, string m);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("wrong value at %0t: %s got %b exp %b", $time, m, g, e);
    end
  endtask : chk_bit

  task automatic timed_out(string m);
    errors++;
    $display("wrong value at %0t: %s timed out", $time, m);
    final_report();
  endtask : timed_out

  // ****************************************************************
  // bus and stimulus helpers
  // ****************************************************************
  // one apb transfer; request held until pready is seen at an edge
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d,
                     output logic [31:0] r, output logic err);
    int k;
    @(posedge clk_sys_i);
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a,
                 pwdata: d};
    @(posedge clk_sys_i);
    apb_req.penable <= 1'b1;
    for (k = 0; k < 16; k++) begin
      @(posedge clk_sys_i);
      if (apb_rsp.pready === 1'b1) break;
    end
    if (k == 16) timed_out("apb");
    r   = apb_rsp.prdata;
    err = apb_rsp.pslverr;
    apb_req.psel    <= 1'b0;
    apb_req.penable <= 1'b0;
  endtask : apb

  task automatic wr(logic [11:0] a, logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask : wr

  task automatic rd_chk(logic [11:0] a, logic [31:0] x, string m);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h00000000, r, e);
    chk_val(r, x, m);
  endtask : rd_chk

  task automatic ticks(int n);
    repeat (n) @(posedge clk_sys_i);
  endtask : ticks

  task automatic pulse(int n);
    @(posedge clk_sys_i);
    irq_lines <= 20'h00001 << n;
    @(posedge clk_sys_i);
    irq_lines <= 20'h00000;
  endtask : pulse

  // a pulse is caught at whichever of the next edges carries it
  task automatic watch_wake(output logic seen);
    seen = 1'b0;
    repeat (8) begin
      @(posedge clk_sys_i);
      if (wake === 1'b1) seen = 1'b1;
    end
  endtask : watch_wake

  task automatic fetch_chk(logic [1:0] dl, logic [23:0] x, string m);
    int k;
    @(posedge clk_sys_i);
    start <= 1'b1;
    delay <= dl;
    @(posedge clk_sys_i);
    start <= 1'b0;
    for (k = 0; k < 16; k++) begin
      @(posedge clk_sys_i);
      if (done === 1'b1) break;
    end
    if (k == 16) timed_out("fetch");
    chk_val({8'h00, got}, {8'h00, x}, m);
    chk_bit(bad, 1'b0, "answer slot");
  endtask : fetch_chk

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_reset();
    logic [31:0] r;
    logic        e;
    chk_val({8'h00, vec_addr}, 32'h00008000, "reset vec");
    chk_bit(irq, 1'b0, "irq after reset");
    rd_chk(`IVW_OFS_STATUS, 32'h00000000, "status rst");
    rd_chk(`IVW_OFS_MASK, 32'h00000000, "mask rst");
    apb(1'b0, 12'h020, 32'h00000000, r, e);
    chk_bit(e, 1'b1, "unmapped err");
    chk_val(r, 32'h00000000, "unmapped data");
    $display("test reset done");
  endtask : t_reset

  task automatic t_vectors();
    wr(`IVW_OFS_MASK, 32'h000FFFFF);
    for (int n = 0; n < 20; n++) begin
      if (RSVD[n]) continue;
      pulse(n);
      fetch_chk(2'(n % 3), 24'h008008 + 24'(4 * n), "line vec");
      wr(`IVW_OFS_STATUS, 32'h1 << n);
    end
    pulse(12);
    pulse(5);
    fetch_chk(2'h0, 24'h00801C, "lowest pending");
    wr(`IVW_OFS_STATUS, 32'h000FFFFF);
    fetch_chk(2'h1, 24'h008000, "nothing pending");
    rd_chk(`IVW_OFS_VECTOR, 32'h00008000, "vector reg");
    for (int n = 0; n < 20; n++) begin
      if (!RSVD[n]) continue;
      pulse(n);
      rd_chk(`IVW_OFS_STATUS, 32'h00000000, "reserved line");
    end
    $display("test vectors done");
  endtask : t_vectors

  task automatic t_trap();
    logic s;
    @(posedge clk_sys_i);
    trap <= 1'b1;
    @(posedge clk_sys_i);
    trap <= 1'b0;
    wr(`IVW_OFS_CTRL, `IVW_MODE_HALT);
    watch_wake(s);
    chk_bit(s, 1'b0, "trap wake");
    chk_bit(halted, 1'b1, "stay halted");
    wr(`IVW_OFS_CTRL, `IVW_MODE_RUN);
    fetch_chk(2'h2, 24'h008004, "trap vec");
    fetch_chk(2'h0, 24'h008000, "trap cleared");
    $display("test trap done");
  endtask : t_trap

  task automatic t_irq();
    wr(`IVW_OFS_MASK, 32'hFFFFFFFF);
    rd_chk(`IVW_OFS_MASK, 32'h000E7DFF, "mask reserved");
    wr(`IVW_OFS_MASK, 32'h00000000);
    pulse(4);
    ticks(2);
    chk_bit(irq, 1'b0, "masked irq");
    rd_chk(`IVW_OFS_STATUS, 32'h00000010, "sticky status");
    wr(`IVW_OFS_MASK, 32'h00000010);
    ticks(2);
    chk_bit(irq, 1'b1, "unmasked irq");
    wr(`IVW_OFS_STATUS, 32'h00000010);
    ticks(2);
    chk_bit(irq, 1'b0, "cleared irq");
    $display("test irq done");
  endtask : t_irq

  task automatic t_wake();
    logic s;
    logic x;
    wr(`IVW_OFS_MASK, 32'h00000000);
    wr(`IVW_OFS_CTRL, `IVW_MODE_HALT);
    pulse(4);
    watch_wake(s);
    chk_bit(s, 1'b0, "masked wake");
    wr(`IVW_OFS_STATUS, 32'h000FFFFF);
    wr(`IVW_OFS_MASK, 32'h000FFFFF);
    for (int m = 1; m < 3; m++) begin
      for (int n = 0; n < 20; n++) begin
        if (RSVD[n]) continue;
        x = (m == 1) ? HALT_SET[n] : AHALT_SET[n];
        wr(`IVW_OFS_CTRL, 32'(m));
        pulse(n);
        watch_wake(s);
        chk_bit(s, x, "wake pulse");
        chk_bit(halted, ~x, "mode after event");
        wr(`IVW_OFS_STATUS, 32'h000FFFFF);
        wr(`IVW_OFS_CTRL, `IVW_MODE_RUN);
      end
    end
    $display("test wake done");
  endtask : t_wake

  task automatic t_pin();
    logic s;
    wr(`IVW_OFS_CTRL, 32'h00000040);
    ticks(4);
    pad_ext <= 1'b0;
    ticks(6);
    rd_chk(`IVW_OFS_STATUS, 32'h00000008, "pin edge line");
    wr(`IVW_OFS_STATUS, 32'h000FFFFF);
    pad_ext <= 1'b1;
    wr(`IVW_OFS_CTRL, 32'h00000070);
    ticks(2);
    chk_bit(pin_oe, 1'b1, "drive in run");
    chk_bit(pin_pu, 1'b0, "no pull in run");
    chk_bit(pin_o, 1'b1, "pin out level");
    wr(`IVW_OFS_CTRL, 32'h00000070 | `IVW_MODE_HALT);
    ticks(2);
    chk_bit(pin_oe, 1'b0, "no drive halted");
    chk_bit(pin_pu, 1'b1, "pull halted");
    pad_ext <= 1'b0;
    watch_wake(s);
    chk_bit(s, 1'b0, "pin wake");
    rd_chk(`IVW_OFS_STATUS, 32'h00000000, "pin halted");
    rd_chk(`IVW_OFS_PIN, 32'h00000000, "pin level reg");
    wr(`IVW_OFS_CTRL, 32'h00000070 | `IVW_MODE_AHALT);
    ticks(2);
    pad_ext <= 1'b1;
    ticks(4);
    pad_ext <= 1'b0;
    watch_wake(s);
    chk_bit(s, 1'b0, "pin wake ahalt");
    chk_bit(pin_oe, 1'b0, "no drive ahalt");
    wr(`IVW_OFS_CTRL, `IVW_MODE_RUN);
    $display("test pin done");
  endtask : t_pin

  // ****************************************************************
  // main sequence and hang guard
  // ****************************************************************
  initial begin
    repeat (20) @(posedge clk_sys_i);
    reset_n_i <= 1'b1;
    t_reset();
    t_vectors();
    t_trap();
    t_irq();
    t_wake();
    t_pin();
    final_report();
  end

  initial begin
    repeat (100000) @(posedge clk_sys_i);
    timed_out("run");
  end
endmodule : tb

`default_nettype wire
